//--- rtl/usml_top.sv
`timescale 1ns/1ps

// Operation
// - load shifter only after previous last bit
// - buffer-to-shifter move sets empty flag
// - empty flag set only while transmit enabled, cleared by write
// - transmit request gated by its enable
// - shift_empty read-only polled status bit
// - flag clear visible three cycles after write
// - buffer write with transmit enabled starts word
// - single or continuous enable starts reception while transmit disabled
// - sample data on falling shift clock
// - single enable receives exactly one word
// - continuous enable receives until cleared
// - both enables set behave as continuous
// - word done sets full flag, gated request
// - clearing continuous enable clears errors
// - shift register has no address
// - clock source clear means external clock
// - link is half duplex
// - sync mode and port enable claim pins
// - master drives shift clock line
module usml_top (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [usml_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// shift clock pin
	input wire logic shift_clock_in,
	output logic shift_clock_out,
	output logic shift_clock_oe_n,
	// shift data pin
	input wire logic shift_data_in,
	output logic shift_data_out,
	output logic shift_data_oe_n,
	// interrupt requests
	output logic tx_irq_req,
	output logic rx_irq_req
);
	import usml_pkg::*;

	// ======================================================================
	// state record

	typedef struct packed {
		usml_state_type st;      // link sequencer
		logic [7:0] irq_en;      // periph_irq_enables
		logic [7:0] irq_pri;     // periph_irq_priority, storage only
		logic tx_flag;           // tx_buffer_empty_flag
		logic rx_flag;           // rx_full_flag
		logic [7:0] txs;         // tx_control_status writable bits
		logic [7:0] rxs;         // rx_control_status bits
		logic [7:0] tx_buf;      // tx_buffer
		logic buf_full;          // tx_buffer holds a word
		logic [1:0] clr_pipe;    // delay of the flag clear after a write
		logic [7:0] rate;        // rate_divisor
		logic [7:0] rx_buf;      // rx_buffer
		logic [8:0] shifter;     // tx_shift_reg or receive shifter
		logic [3:0] bit_cnt;     // bits done in the word
		logic [7:0] div_cnt;     // shift clock divider
		logic clk_lvl;           // generated shift clock level
		logic ck_s1;             // clock pin synchroniser, first stage
		logic ck_s2;             // clock pin synchroniser, second stage
		logic ck_s3;             // previous synchronised clock level
		logic dt_s1;             // data pin synchroniser, first stage
		logic dt_s2;             // data pin synchroniser, second stage
		logic ck_out;            // clock pin output
		logic ck_oe_n;           // clock pin enable, low drives
		logic dt_out;            // data pin output
		logic dt_oe_n;           // data pin enable, low drives
		logic [31:0] rdata;      // apb read data
		logic rdy;               // apb ready
		logic err;               // apb slave error
		logic tx_irq;            // transmit request
		logic rx_irq;            // receive request
	} usml_regs_type;

	usml_regs_type q;
	usml_regs_type d;

	// ======================================================================
	// next-state logic

	// one process computes every next value
	always_comb begin
		logic master;
		logic link_on;
		logic setup;
		logic wr;
		logic rd;
		logic tick;
		logic rise_ev;
		logic fall_ev;
		logic load;
		logic rx_on;
		logic [3:0] last_bit;
		logic [8:0] word;
		logic [7:0] rd_val;
		logic mapped;

		d = q;
		// edge strobes start inactive on every pass
		tick = 1'b0;
		rise_ev = 1'b0;
		fall_ev = 1'b0;
		master = q.txs[TXS_CLK_SRC];
		link_on = q.rxs[RXS_PORT_EN] && q.txs[TXS_SYNC];
		rx_on = q.rxs[RXS_SINGLE] || q.rxs[RXS_CONT];
		setup = psel && !penable;
		wr = psel && penable && q.rdy && pwrite;
		rd = psel && penable && q.rdy && !pwrite;
		load = 1'b0;
		last_bit = LAST_BIT_8;
		word = q.shifter;
		rd_val = RST_ZERO;
		mapped = 1'b1;

		// pin synchronisers, first stage read only by the second
		d.ck_s1 = shift_clock_in;
		d.ck_s2 = q.ck_s1;
		d.ck_s3 = q.ck_s2;
		d.dt_s1 = shift_data_in;
		d.dt_s2 = q.dt_s1;

		// apb: answer in the access phase after every setup cycle
		d.rdy = setup;
		if (setup) begin
			case (paddr)
				OFS_IRQ_FLAGS: begin
					rd_val[IRQ_TX_BIT] = q.tx_flag;
					rd_val[IRQ_RX_BIT] = q.rx_flag;
				end
				OFS_IRQ_ENABLES: rd_val = q.irq_en;
				OFS_IRQ_PRIORITY: rd_val = q.irq_pri;
				OFS_RX_CTRL: rd_val = q.rxs;
				OFS_TX_BUFFER: rd_val = q.tx_buf;
				OFS_TX_CTRL: begin
					rd_val = q.txs & TXS_WR_MASK;
					rd_val[TXS_SHIFT_EMPTY] = (q.st != ST_TX);
				end
				OFS_RATE: rd_val = q.rate;
				OFS_RX_BUFFER: rd_val = q.rx_buf;
				// tx_shift_reg has no address of its own
				default: mapped = 1'b0;
			endcase
			d.rdata = {24'h000000, rd_val};
			d.err = !mapped;
		end

		// apb writes; flags are read-only to software
		if (wr) begin
			case (paddr)
				OFS_IRQ_ENABLES: d.irq_en = pwdata[7:0];
				OFS_IRQ_PRIORITY: d.irq_pri = pwdata[7:0];
				OFS_RX_CTRL: begin
					d.rxs = (q.rxs & ~RXS_WR_MASK) | (pwdata[7:0] & RXS_WR_MASK);
					// dropping continuous reception clears the error
					if (!pwdata[RXS_CONT]) begin
						d.rxs[RXS_OVERRUN] = 1'b0;
					end
				end
				OFS_TX_CTRL: d.txs = pwdata[7:0] & TXS_WR_MASK;
				OFS_RATE: begin
					d.rate = pwdata[7:0];
					d.div_cnt = pwdata[7:0];
				end
				default: begin
				end
			endcase
		end

		// reading the receive buffer empties it
		if (rd && paddr == OFS_RX_BUFFER) begin
			d.rx_flag = 1'b0;
		end

		// shift clock: divider in master mode, pin edges in slave mode
		if (master && q.st != ST_IDLE) begin
			if (q.div_cnt == 8'h00) begin
				tick = 1'b1;
				d.div_cnt = q.rate;
				d.clk_lvl = !q.clk_lvl;
			end else begin
				d.div_cnt = q.div_cnt - 8'h01;
			end
		end
		if (master) begin
			rise_ev = tick && !q.clk_lvl;
			fall_ev = tick && q.clk_lvl;
		end else begin
			rise_ev = q.ck_s2 && !q.ck_s3;
			fall_ev = !q.ck_s2 && q.ck_s3;
		end

		// link sequencer
		unique case (q.st)
			// idle: transmit has priority, reception waits
			ST_IDLE: begin
				d.clk_lvl = 1'b0;
				d.div_cnt = q.rate;
				d.bit_cnt = 4'h0;
				if (link_on && q.txs[TXS_TX_EN] && q.buf_full) begin
					load = 1'b1;
					d.st = ST_TX;
				end else if (link_on && rx_on && !q.txs[TXS_TX_EN]) begin
					d.st = ST_RX;
				end
			end
			// transmit: next bit after each falling shift clock edge
			ST_TX: begin
				if (!link_on || !q.txs[TXS_TX_EN]) begin
					d.st = ST_IDLE;
				end else if (fall_ev) begin
					last_bit = q.txs[TXS_NINTH_EN] ? LAST_BIT_9 : LAST_BIT_8;
					if (q.bit_cnt == last_bit) begin
						d.bit_cnt = 4'h0;
						// next word follows at once if one waits
						if (q.buf_full) begin
							load = 1'b1;
						end else begin
							d.st = ST_IDLE;
						end
					end else begin
						d.shifter = {1'b0, q.shifter[8:1]};
						d.bit_cnt = q.bit_cnt + 4'h1;
					end
				end
			end
			// receive: sample data on the falling edge
			ST_RX: begin
				if (!link_on || !rx_on) begin
					d.st = ST_IDLE;
				end else if (fall_ev) begin
					last_bit = q.rxs[RXS_NINTH_EN] ? LAST_BIT_9 : LAST_BIT_8;
					word = {q.dt_s2, q.shifter[8:1]};
					d.shifter = word;
					d.bit_cnt = q.bit_cnt + 4'h1;
					if (q.bit_cnt == last_bit) begin
						d.bit_cnt = 4'h0;
						// full buffer not yet read loses the word
						if (q.rx_flag && !(rd && paddr == OFS_RX_BUFFER)) begin
							d.rxs[RXS_OVERRUN] = 1'b1;
						end else begin
							d.rx_flag = 1'b1;
							if (q.rxs[RXS_NINTH_EN]) begin
								d.rx_buf = word[7:0];
								d.rxs[RXS_NINTH_BIT] = word[8];
							end else begin
								d.rx_buf = word[8:1];
							end
						end
						// single mode stops, continuous wins
						if (!q.rxs[RXS_CONT]) begin
							d.rxs[RXS_SINGLE] = 1'b0;
							d.st = ST_IDLE;
						end
					end
				end
			end
		endcase

		// move the buffer into the shifter in one cycle
		if (load) begin
			d.shifter = {q.txs[TXS_NINTH_BIT], q.tx_buf};
			d.buf_full = 1'b0;
			d.bit_cnt = 4'h0;
		end

		// a buffer write always wins over the move that empties it
		d.clr_pipe = {q.clr_pipe[0], wr && paddr == OFS_TX_BUFFER};
		if (wr && paddr == OFS_TX_BUFFER) begin
			d.tx_buf = pwdata[7:0];
			d.buf_full = 1'b1;
		end

		// empty flag: delayed clear, set wins
		if (q.clr_pipe[1] && d.buf_full) begin
			d.tx_flag = 1'b0;
		end
		if (load || (q.txs[TXS_TX_EN] && !q.buf_full && !q.clr_pipe[1])) begin
			d.tx_flag = 1'b1;
		end

		// pins: clock driven only as master, data only while sending
		d.ck_oe_n = !(link_on && master);
		d.ck_out = d.clk_lvl;
		d.dt_oe_n = !(link_on && d.st == ST_TX);
		d.dt_out = d.shifter[0];

		// interrupt requests gated by their enables
		d.tx_irq = d.tx_flag && d.irq_en[IRQ_TX_BIT];
		d.rx_irq = d.rx_flag && d.irq_en[IRQ_RX_BIT];

		// rise events only matter for slave timing hazards
		if (rise_ev && q.st == ST_IDLE) begin
			d.bit_cnt = 4'h0;
		end
	end

	// ======================================================================
	// state register

	// synchronous reset to documented values
	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.txs <= RST_TX_CTRL & TXS_WR_MASK;
			q.ck_oe_n <= 1'b1;
			q.dt_oe_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ======================================================================
	// outputs straight from the state register

	assign prdata = q.rdata;
	assign pready = q.rdy;
	assign pslverr = q.err;
	assign shift_clock_out = q.ck_out;
	assign shift_clock_oe_n = q.ck_oe_n;
	assign shift_data_out = q.dt_out;
	assign shift_data_oe_n = q.dt_oe_n;
	assign tx_irq_req = q.tx_irq;
	assign rx_irq_req = q.rx_irq;

endmodule // usml_top

//--- rtl/usml_pkg.sv
// ==========================================================================
// shared constants of the synchronous serial link
package usml_pkg;

	// apb address width and register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_IRQ_FLAGS = 8'h00;
	localparam logic [7:0] OFS_IRQ_ENABLES = 8'h04;
	localparam logic [7:0] OFS_IRQ_PRIORITY = 8'h08;
	localparam logic [7:0] OFS_RX_CTRL = 8'h0C;
	localparam logic [7:0] OFS_TX_BUFFER = 8'h10;
	localparam logic [7:0] OFS_TX_CTRL = 8'h14;
	localparam logic [7:0] OFS_RATE = 8'h18;
	localparam logic [7:0] OFS_RX_BUFFER = 8'h1C;

	// flag and enable positions in the peripheral irq registers
	localparam int IRQ_TX_BIT = 4;
	localparam int IRQ_RX_BIT = 5;

	// tx_control_status fields
	localparam int TXS_CLK_SRC = 7;
	localparam int TXS_NINTH_EN = 6;
	localparam int TXS_TX_EN = 5;
	localparam int TXS_SYNC = 4;
	localparam int TXS_SHIFT_EMPTY = 1;
	localparam int TXS_NINTH_BIT = 0;

	// rx_control_status fields
	localparam int RXS_PORT_EN = 7;
	localparam int RXS_NINTH_EN = 6;
	localparam int RXS_SINGLE = 5;
	localparam int RXS_CONT = 4;
	localparam int RXS_FRAMING = 2;
	localparam int RXS_OVERRUN = 1;
	localparam int RXS_NINTH_BIT = 0;

	// software-writable bits of each control register
	localparam logic [7:0] TXS_WR_MASK = 8'hF5;
	localparam logic [7:0] RXS_WR_MASK = 8'hF8;

	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_TX_CTRL = 8'h02;

	// last bit index of a word, eight or nine bits long
	localparam logic [3:0] LAST_BIT_8 = 4'h7;
	localparam logic [3:0] LAST_BIT_9 = 4'h8;

	// link sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_TX = 3'b010,
		ST_RX = 3'b100
	} usml_state_type;

endpackage

//--- test/usml_checker.sv
`timescale 1ns/1ps
// ==========
// port checker of the serial link
module usml_checker
	import usml_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [usml_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// link pins
	input wire logic shift_clock_out,
	input wire logic shift_clock_oe_n,
	input wire logic shift_data_out,
	input wire logic shift_data_oe_n,
	// requests
	input wire logic tx_irq_req,
	input wire logic rx_irq_req
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic [7:0] txs_q, rxs_q, en_q, rate_q; // last written values
	logic [9:0] run_q; // cycles since the clock line moved
	logic seen_q; // a toggle already seen since the data pin was driven
	wire wr = psel && penable && pready && pwrite;
	wire ok = txs_q[TXS_CLK_SRC] && txs_q[TXS_SYNC] && rxs_q[RXS_PORT_EN];
	// mirror software writes
	always_ff @(posedge clk) begin
		if (srst) begin
			txs_q <= 8'h00;
			rxs_q <= 8'h00;
			en_q <= 8'h00;
			rate_q <= 8'h00;
		end else if (wr) begin
			if (paddr == OFS_TX_CTRL) txs_q <= pwdata[7:0];
			if (paddr == OFS_RX_CTRL) rxs_q <= pwdata[7:0];
			if (paddr == OFS_IRQ_ENABLES) en_q <= pwdata[7:0];
			if (paddr == OFS_RATE) rate_q <= pwdata[7:0];
		end
	end
	// time each half period while sending
	always_ff @(posedge clk) begin
		run_q <= $changed(shift_clock_out) ? 10'h001 : run_q + 10'h001;
		seen_q <= !srst && !shift_data_oe_n && (seen_q || $changed(shift_clock_out));
	end
	sequence buf_write;
		wr && paddr == OFS_TX_BUFFER && ok && txs_q[TXS_TX_EN] && shift_data_oe_n;
	endsequence
	tx_start_a: assert property (buf_write |-> ##[1:4] !shift_data_oe_n)
		else $error("word did not start");
	tx_gate_a: assert property (tx_irq_req |-> en_q[4] || $past(en_q[4]))
		else $error("tx request not gated");
	rx_gate_a: assert property (rx_irq_req |-> en_q[5] || $past(en_q[5]))
		else $error("rx request not gated");
	bad_addr_a: assert property (pready |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0))
		else $error("error response wrong");
	clk_drive_a: assert property (!shift_clock_oe_n |-> $past(ok) || $past(ok, 2))
		else $error("clock driven outside master mode");
	duplex_a: assert property (!shift_data_oe_n |-> $past(txs_q[5]) || $past(txs_q[5], 2))
		else $error("data driven without transmit");
	half_period_a: assert property (!shift_data_oe_n && seen_q
		&& $changed(shift_clock_out) |-> run_q == {2'h0, rate_q} + 10'h001)
		else $error("half period wrong");
	data_hold_a: assert property (!shift_data_oe_n && shift_clock_out
		|-> $stable(shift_data_out))
		else $error("data moved while clock high");
endmodule // usml_checker

//--- test/usml_peer.sv
`timescale 1ns/1ps
// ==========
// external peer on the clock and data lines
module usml_peer (
	// device pin drivers
	input wire logic ck_out,
	input wire logic ck_oe_n,
	input wire logic dt_out,
	input wire logic dt_oe_n,
	// bench control
	input wire logic clr,
	input wire logic [7:0] send_byte,
	input wire logic ext_go,
	input wire logic [3:0] ext_bits,
	// lines and capture
	output logic ck_line,
	output logic dt_line,
	output logic [15:0] got,
	output int n_got
);
	int k = 0; // rising edges while the device listens
	logic pck = 1'h0; // peer's own shift clock, still and low outside a frame
	// the peer's own clock drives the line whenever the device lets it go
	assign ck_line = ck_oe_n ? pck : ck_out;
	// one frame of slave clock pulses, 320 ns period
	always @(posedge ext_go) begin
		repeat (ext_bits) begin
			#160 pck = 1'h1;
			#160 pck = 1'h0;
		end
	end
	// pull-up on data; peer talks only when the device lets go
	assign dt_line = !dt_oe_n ? dt_out : (k == 0 ? 1'h1 : send_byte[(k - 1) % 8]);
	// new bit after each rise, steady at the fall
	always @(posedge ck_line) begin
		if (!dt_oe_n) begin
			got = {dt_line, got[15:1]};
			n_got = n_got + 1;
		end else k = k + 1;
	end
	// restart between scenarios
	always @(posedge clr) begin
		k = 0;
		got = 16'h0000;
		n_got = 0;
	end
endmodule // usml_peer

//--- test/test_usart_sync_master_link.sv
`timescale 1ns/1ps
// ==========
// bench for the serial link
module test_usart_sync_master_link;
	import usml_pkg::*;
	logic clk, srst, psel, penable, pwrite, pready, pslverr, err, peer_clr, ext_go;
	logic [3:0] ext_bits;
	logic shift_clock_out, shift_clock_oe_n, shift_data_out, shift_data_oe_n;
	logic tx_irq_req, rx_irq_req, ck_line, dt_line;
	logic [7:0] paddr, send_byte;
	logic [31:0] pwdata, prdata, rv;
	logic [15:0] got;
	int n_got, n_mismatch = 0, n_checks = 0;
	usml_top usml_top_i (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .shift_clock_in(ck_line), .shift_clock_out, .shift_clock_oe_n,
		.shift_data_in(dt_line), .shift_data_out, .shift_data_oe_n, .tx_irq_req, .rx_irq_req);
	usml_peer usml_peer_i (.ck_out(shift_clock_out), .ck_oe_n(shift_clock_oe_n),
		.dt_out(shift_data_out), .dt_oe_n(shift_data_oe_n), .clr(peer_clr), .send_byte,
		.ext_go, .ext_bits, .ck_line, .dt_line, .got, .n_got);
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rv = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic restart_peer();
		peer_clr <= 1'h1;
		@(posedge clk);
		peer_clr <= 1'h0;
	endtask
	task automatic t_regs();
		apb(1'h0, OFS_TX_CTRL, 8'h00);
		chk(rv, 32'h02);
		apb(1'h0, 8'h20, 8'h00);
		chk({31'h0, err}, 32'h1);
		$display("regs done");
	endtask
	task automatic t_tx();
		apb(1'h1, OFS_RATE, 8'h03);
		apb(1'h1, OFS_RX_CTRL, 8'h80);
		apb(1'h1, OFS_IRQ_ENABLES, 8'h30); // core enables lie outside, requests watched
		apb(1'h1, OFS_TX_CTRL, 8'hB0);
		apb(1'h0, OFS_IRQ_FLAGS, 8'h00);
		chk(rv, 32'h10);
		apb(1'h1, OFS_TX_BUFFER, 8'hA5);
		apb(1'h1, OFS_TX_BUFFER, 8'h3C);
		apb(1'h1, OFS_IRQ_FLAGS, 8'h10);
		apb(1'h0, OFS_IRQ_FLAGS, 8'h00);
		chk(rv, 32'h00);
		apb(1'h0, OFS_TX_CTRL, 8'h00);
		chk(rv, 32'hB0);
		repeat (600) if (n_got < 16) @(posedge clk);
		chk({16'h0000, got}, 32'h3CA5);
		repeat (10) @(posedge clk);
		apb(1'h0, OFS_IRQ_FLAGS, 8'h00);
		chk(rv, 32'h10);
		apb(1'h0, OFS_TX_CTRL, 8'h00);
		chk(rv, 32'hB2);
		chk({31'h0, tx_irq_req}, 32'h1);
		apb(1'h1, OFS_IRQ_ENABLES, 8'h20);
		@(posedge clk);
		chk({31'h0, tx_irq_req}, 32'h0);
		// nine-bit word, ninth bit preloaded high and sent last
		apb(1'h1, OFS_TX_CTRL, 8'hF1);
		restart_peer();
		apb(1'h1, OFS_TX_BUFFER, 8'h5A);
		repeat (600) if (n_got < 9) @(posedge clk);
		chk({23'h0, got[15:7]}, 32'h15A);
		$display("tx done");
	endtask
	task automatic t_rx();
		apb(1'h1, OFS_TX_CTRL, 8'h90);
		send_byte <= 8'h6B;
		restart_peer();
		apb(1'h1, OFS_RX_CTRL, 8'hA0);
		repeat (600) if (rx_irq_req !== 1'h1) @(posedge clk);
		chk({31'h0, rx_irq_req}, 32'h1);
		apb(1'h0, OFS_RX_CTRL, 8'h00);
		chk(rv, 32'h80);
		apb(1'h0, OFS_RX_BUFFER, 8'h00);
		chk(rv, 32'h6B);
		repeat (200) @(posedge clk);
		chk({31'h0, rx_irq_req}, 32'h0);
		restart_peer();
		apb(1'h1, OFS_RX_CTRL, 8'hB0);
		repeat (300) @(posedge clk);
		apb(1'h0, OFS_RX_CTRL, 8'h00);
		chk(rv & 32'h12, 32'h12);
		apb(1'h0, OFS_RX_BUFFER, 8'h00);
		chk(rv, 32'h6B);
		apb(1'h1, OFS_RX_CTRL, 8'h80);
		apb(1'h0, OFS_RX_CTRL, 8'h00);
		chk(rv, 32'h80);
		$display("rx done");
	endtask
	// slave reception: the peer clocks a nine-bit word in
	task automatic t_slave();
		apb(1'h1, OFS_TX_CTRL, 8'h10);
		send_byte <= 8'hC3;
		ext_bits <= 4'h9;
		restart_peer();
		apb(1'h1, OFS_RX_CTRL, 8'hD0);
		ext_go <= 1'h1;
		@(posedge clk);
		ext_go <= 1'h0;
		repeat (200) if (rx_irq_req !== 1'h1) @(posedge clk);
		chk({31'h0, rx_irq_req}, 32'h1);
		chk({31'h0, shift_clock_oe_n}, 32'h1);
		apb(1'h0, OFS_RX_CTRL, 8'h00);
		chk(rv, 32'hD1);
		apb(1'h0, OFS_RX_BUFFER, 8'h00);
		chk(rv, 32'hC3);
		apb(1'h1, OFS_RX_CTRL, 8'h80);
		$display("slave done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		{srst, psel, penable, pwrite, peer_clr, ext_go} = 6'h20;
		{paddr, send_byte, pwdata, ext_bits} = 52'h0;
		repeat (2) @(posedge clk);
		srst <= 1'h0;
		restart_peer();
		t_regs();
		t_tx();
		t_rx();
		t_slave();
		report_and_stop();
	end
	initial begin
		#1000000;
		n_mismatch++;
		report_and_stop();
	end
endmodule // test_usart_sync_master_link
bind usml_top usml_checker usml_checker_i (.clk, .srst, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .shift_clock_out, .shift_clock_oe_n, .shift_data_out,
	.shift_data_oe_n, .tx_irq_req, .rx_irq_req);
